// >>> src/btc_cmd_top.sv
// serial command front end: page transfer, compare, refresh and status streaming
`default_nettype none

module btc_cmd_top #(
    parameter int COPY_CYCLES = btc_pkg::COPY_CYCLES,
    parameter int COMP_CYCLES = btc_pkg::COMP_CYCLES,
    parameter int REFRESH_CYCLES = btc_pkg::REFRESH_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial pins
    input wire btc_pkg::btc_pins_t pins,
    output logic so_out,
    output logic so_oe,
    // device core state
    input wire logic protect_en,
    input wire logic page_bin_cfg,
    input wire logic buffer1_suspend_flag,
    input wire logic buffer2_suspend_flag,
    input wire logic cmp_mismatch,
    // operation request to the array core
    output btc_pkg::btc_op_t op,
    output logic ready
);
    import btc_pkg::*;

    logic rst_meta;
    logic rst_n_s;
    btc_pins_t pins_f;
    logic cs_q;
    logic sck_q;
    btc_state_t st;
    logic [7:0] opc;
    logic [23:0] addr;
    logic [5:0] rx_cnt;
    logic addr_done;
    logic [2:0] data_bits;
    logic data_seen;
    logic comp;
    logic [7:0] out_sh;
    logic [2:0] sbit;
    logic sbyte;
    logic t_busy;
    logic t_done;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n_s <= rst_meta;
        end
    end

    btc_pin_sync #(.W(3), .RST(PINS_RST)) u_sync (
        .clk(clk),
        .rst_n(rst_n_s),
        .d(pins),
        .q(pins_f)
    );

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            cs_q <= 1'b1;
            sck_q <= 1'b0;
        end
        else
        begin
            cs_q <= pins_f.cs_n;
            sck_q <= pins_f.sck;
        end
    end

    wire active = !pins_f.cs_n;
    wire cs_fall = !pins_f.cs_n && cs_q;
    wire cs_rise = pins_f.cs_n && !cs_q;
    wire sck_rise = active && pins_f.sck && !sck_q;
    wire sck_fall = active && !pins_f.sck && sck_q;
    wire [7:0] opc_next = {opc[6:0], pins_f.si};

    function automatic logic is_array_op(input logic [7:0] o);
        return o == OPC_XFER_B1 || o == OPC_XFER_B2 || o == OPC_CMP_B1 || o == OPC_CMP_B2
            || o == OPC_RFR_B1 || o == OPC_RFR_B2;
    endfunction : is_array_op

    wire is_rfr = (opc == OPC_RFR_B1) || (opc == OPC_RFR_B2);
    wire is_cmp = (opc == OPC_CMP_B1) || (opc == OPC_CMP_B2);
    wire is_b2 = (opc == OPC_XFER_B2) || (opc == OPC_CMP_B2) || (opc == OPC_RFR_B2);

    // command framing; host keeps select low for the whole command
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            st <= ST_OPC;
            opc <= 8'h00;
            addr <= 24'h000000;
            rx_cnt <= 6'h00;
            addr_done <= 1'b0;
            data_bits <= 3'h0;
            data_seen <= 1'b0;
        end
        else if (cs_fall)
        begin
            st <= ST_OPC;
            rx_cnt <= 6'h00;
            addr_done <= 1'b0;
            data_bits <= 3'h0;
            data_seen <= 1'b0;
        end
        else if (sck_rise)
        begin
            unique case (st)
                ST_OPC:
                begin
                    opc <= opc_next;
                    rx_cnt <= rx_cnt + 6'h01;
                    if (rx_cnt == OPC_LAST)
                    begin
                        if (opc_next == OPC_STATUS)
                            st <= ST_STAT;
                        else if (is_array_op(opc_next))
                            st <= ST_ADDR;
                        else
                            st <= ST_IGN;
                    end
                end
                ST_ADDR:
                begin
                    addr <= {addr[22:0], pins_f.si};
                    rx_cnt <= rx_cnt + 6'h01;
                    if (rx_cnt == CMD_LAST)
                    begin
                        addr_done <= 1'b1;
                        st <= is_rfr ? ST_DATA : ST_IGN;
                    end
                end
                ST_DATA:
                begin
                    data_bits <= data_bits + 3'h1;
                    if (data_bits == 3'h7)
                        data_seen <= 1'b1;
                end
                ST_STAT, ST_IGN:
                begin
                end
                default:
                    st <= ST_IGN;
            endcase
        end
    end

    // request decode, evaluated at the select rise
    btc_op_kind_t kind;
    logic [PAGE_W-1:0] page;
    logic susp;
    logic go;
    always_comb
    begin
        if (is_cmp)
            kind = OP_CMP;
        else if (is_rfr)
            kind = data_seen ? OP_RMW : OP_RFR;
        else
            kind = OP_XFER;
        page = page_bin_cfg ? addr[PAGE_BIN_LSB +: PAGE_W] : addr[PAGE_STD_LSB +: PAGE_W];
        susp = is_b2 ? buffer2_suspend_flag : buffer1_suspend_flag;
        // a busy device also starts nothing; compare leaves the buffer intact
        go = cs_rise && addr_done && ready && !(susp && kind != OP_CMP);
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            op <= '0;
        else
        begin
            op.start <= go;
            if (go)
            begin
                op.kind <= kind;
                op.buffer2 <= is_b2;
                op.page <= page;
            end
        end
    end

    logic [TIMER_W-1:0] t_load;
    always_comb
    begin
        unique case (kind)
            OP_XFER: t_load = TIMER_W'(COPY_CYCLES);
            OP_CMP: t_load = TIMER_W'(COMP_CYCLES);
            OP_RFR, OP_RMW: t_load = TIMER_W'(REFRESH_CYCLES);
        endcase
    end

    btc_op_timer #(.CW(TIMER_W)) u_timer (
        .clk(clk),
        .rst_n(rst_n_s),
        .load(go),
        .count(t_load),
        .busy(t_busy),
        .done(t_done)
    );

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            ready <= 1'b1;
        else if (go)
            ready <= 1'b0;
        else if (t_done)
            ready <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
            comp <= COMP_RST;
        else if (t_done && op.kind == OP_CMP)
            comp <= cmp_mismatch;
    end

    // status bytes; byte two carries only the ready flag here
    logic [7:0] stat1;
    logic [7:0] stat2;
    always_comb
    begin
        stat1 = 8'h00;
        stat1[ST_READY] = ready;
        stat1[ST_COMP] = comp;
        stat1[ST_DENS_LSB +: 4] = DENSITY_CODE;
        stat1[ST_PROT] = protect_en;
        stat1[ST_PSIZE] = page_bin_cfg;
        stat2 = 8'h00;
        stat2[ST_READY] = ready;
    end

    // status shifts out on falling edges; each byte samples fresh state when it starts
    always_ff @(posedge clk or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            so_out <= 1'b0;
            so_oe <= 1'b0;
            out_sh <= 8'h00;
            sbit <= 3'h0;
            sbyte <= 1'b0;
        end
        else if (!active)
        begin
            so_oe <= 1'b0;
            sbit <= 3'h0;
            sbyte <= 1'b0;
        end
        else if (st == ST_STAT && sck_fall)
        begin
            so_oe <= 1'b1;
            if (sbit == 3'h0)
            begin
                so_out <= sbyte ? stat2[7] : stat1[7];
                out_sh <= sbyte ? {stat2[6:0], 1'b0} : {stat1[6:0], 1'b0};
            end
            else
            begin
                so_out <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
            sbit <= sbit + 3'h1;
            if (sbit == 3'h7)
                sbyte <= !sbyte;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n_s);

    sequence s_started;
        op.start ##1 !ready;
    endsequence

    a_xfer_busy: assert property (op.start && op.kind == OP_XFER |-> !ready ##1 !ready)
        else $error("transfer did not hold busy");
    a_refresh_busy: assert property (op.start && op.kind inside {OP_RFR, OP_RMW} |-> !ready [*8])
        else $error("refresh not busy for its run");
    a_comp_result: assert property (t_done && op.kind == OP_CMP |=> comp == $past(cmp_mismatch))
        else $error("compare result not stored");
    a_rmw_select: assert property (go && is_rfr |=> op.kind == ($past(data_seen) ? OP_RMW : OP_RFR))
        else $error("refresh kind wrong");
    a_full_cmd: assert property (cs_rise && !addr_done |=> !op.start)
        else $error("started on a partial command");
    a_susp_block: assert property (cs_rise && susp && !is_cmp |=> !op.start)
        else $error("modified a suspended buffer");
    a_release_out: assert property (!active |=> !so_oe)
        else $error("output held after select rise");
    a_stat_drive: assert property (st == ST_STAT && sck_fall |=> so_oe)
        else $error("status not driven");
    a_byte_wrap: assert property (st == ST_STAT && sck_fall && sbit == 3'h7 && sbyte |=> !sbyte)
        else $error("status did not wrap to byte one");
    a_ready_bit: assert property (st == ST_STAT && sck_fall && sbit == 3'h0 |=> so_out == $past(ready))
        else $error("ready flag not first bit");
    a_start_ready: assert property (s_started |-> $past(t_busy))
        else $error("start without timer");
endmodule : btc_cmd_top

`default_nettype wire

// >>> include/btc_pkg.sv
// package: constants and types for the buffer transfer, compare, refresh and status command block
`default_nettype none

package btc_pkg;
    // opcodes
    localparam logic [7:0] OPC_XFER_B1 = 8'h53;
    localparam logic [7:0] OPC_XFER_B2 = 8'h55;
    localparam logic [7:0] OPC_CMP_B1 = 8'h60;
    localparam logic [7:0] OPC_CMP_B2 = 8'h61;
    localparam logic [7:0] OPC_RFR_B1 = 8'h58;
    localparam logic [7:0] OPC_RFR_B2 = 8'h59;
    localparam logic [7:0] OPC_STATUS = 8'hD7;

    // command framing, counted in received bits
    localparam logic [5:0] OPC_LAST = 6'h07;
    localparam logic [5:0] CMD_LAST = 6'h1F;
    localparam int PAGE_W = 15;
    localparam int PAGE_STD_LSB = 9;
    localparam int PAGE_BIN_LSB = 8;

    // status byte one layout
    localparam int ST_READY = 7;
    localparam int ST_COMP = 6;
    localparam int ST_DENS_LSB = 2;
    localparam int ST_PROT = 1;
    localparam int ST_PSIZE = 0;
    // arbitrary value, identifies nothing real
    localparam logic [3:0] DENSITY_CODE = 4'h6;
    localparam logic COMP_RST = 1'b0;
    localparam logic [2:0] PINS_RST = 3'h4;

    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int COPY_TIME_NS = 200000;
    localparam int COMP_TIME_NS = 200000;
    localparam int REFRESH_TIME_NS = 2000000;
    localparam int TIMER_W = 20;
    // longest times round down, never below one cycle
    localparam int COPY_CYCLES = (COPY_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : COPY_TIME_NS / CLK_PERIOD_NS;
    localparam int COMP_CYCLES = (COMP_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : COMP_TIME_NS / CLK_PERIOD_NS;
    localparam int REFRESH_CYCLES = (REFRESH_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : REFRESH_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0]
    {
        OP_XFER = 2'h0,
        OP_CMP = 2'h1,
        OP_RFR = 2'h2,
        OP_RMW = 2'h3
    } btc_op_kind_t;

    typedef enum logic [4:0]
    {
        ST_OPC = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_STAT = 5'b00100,
        ST_DATA = 5'b01000,
        ST_IGN = 5'b10000
    } btc_state_t;

    typedef struct packed
    {
        logic cs_n;
        logic sck;
        logic si;
    } btc_pins_t;

    typedef struct packed
    {
        logic start;
        btc_op_kind_t kind;
        logic buffer2;
        logic [PAGE_W-1:0] page;
    } btc_op_t;
endpackage : btc_pkg

`default_nettype wire

// >>> src/btc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none

module btc_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST = '0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, filtered levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= RST;
            s2 <= RST;
            s3 <= RST;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once stages two and three agree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
                q[i] <= RST[i];
            else if (s2[i] == s3[i])
                q[i] <= s3[i];
        end
    end
endmodule : btc_pin_sync

`default_nettype wire

// >>> src/btc_op_timer.sv
// self-timed operation counter: busy while counting, done pulse at the end
`default_nettype none

module btc_op_timer #(
    parameter int CW = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // load and status
    input wire logic load,
    input wire logic [CW-1:0] count,
    output logic busy,
    output logic done
);
    logic [CW-1:0] cnt;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt <= '0;
        else if (load)
            cnt <= count;
        else if (cnt != '0)
            cnt <= cnt - {{(CW-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            done <= 1'b0;
        else
            done <= !load && (cnt == {{(CW-1){1'b0}}, 1'b1});
    end

    assign busy = (cnt != '0);
endmodule : btc_op_timer

`default_nettype wire

// >>> sim/btc_host_model.sv
// serial host model: drives select, serial clock and data toward the command block
`default_nettype none

module btc_host_model
(
    // system clock paces the serial clock
    input wire logic clk,
    // serial pins
    output var btc_pkg::btc_pins_t pins,
    input wire logic so_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import btc_pkg::*;

    // 800 ns serial period at the 100 ns system clock
    localparam int HALF = 4;

    initial pins = 3'b100;

    task automatic select();
        repeat (2 * HALF) @(negedge clk);
        pins.cs_n = 1'b0;
        repeat (HALF) @(negedge clk);
    endtask : select

    // mode 0; the reply is sampled late in the high phase, since it lags the fall by several clocks
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++)
        begin
            pins.sck = 1'b0;
            pins.si = tx[7 - i];
            repeat (HALF) @(negedge clk);
            pins.sck = 1'b1;
            repeat (HALF) @(negedge clk);
            rx[7 - i] = so_out;
        end
    endtask : xfer

    task automatic deselect();
        pins.sck = 1'b0;
        repeat (HALF) @(negedge clk);
        pins.cs_n = 1'b1;
        // a released data line must not keep its last level
        pins.si = ~pins.si;
    endtask : deselect
endmodule : btc_host_model

`default_nettype wire

// >>> sim/buffer_transfer_status_cmds_test.sv
// self-checking bench for the serial command block
`default_nettype none

module buffer_transfer_status_cmds_test;
    timeunit 1ns;
    timeprecision 1ns;
    import btc_pkg::*;

    // shortened busy times; refresh kept long enough to read status while busy
    localparam int NCOPY = 20;
    localparam int NCOMP = 20;
    localparam int NRFR = 400;

    logic clk;
    logic reset_n;
    btc_pins_t pins;
    logic so_out;
    logic so_oe;
    logic protect_en;
    logic page_bin_cfg;
    logic buffer1_suspend_flag;
    logic buffer2_suspend_flag;
    logic cmp_mismatch;
    btc_op_t op;
    logic ready;
    int num_errors = 0;
    int samples_checked = 0;
    int starts = 0;
    logic comp_exp = COMP_RST;

    btc_cmd_top #(.COPY_CYCLES(NCOPY), .COMP_CYCLES(NCOMP), .REFRESH_CYCLES(NRFR)) btc_cmd_top_i
    (
        .clk(clk), .reset_n(reset_n), .pins(pins), .so_out(so_out), .so_oe(so_oe),
        .protect_en(protect_en), .page_bin_cfg(page_bin_cfg), .buffer1_suspend_flag(buffer1_suspend_flag),
        .buffer2_suspend_flag(buffer2_suspend_flag), .cmp_mismatch(cmp_mismatch), .op(op), .ready(ready)
    );

    btc_host_model btc_host_model_i (.clk(clk), .pins(pins), .so_out(so_out));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
        if (op.start === 1'b1)
            starts <= starts + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    function automatic logic [7:0] stat1(input logic rdy);
        return {rdy, comp_exp, DENSITY_CODE, protect_en, page_bin_cfg};
    endfunction : stat1

    task automatic check_status(input logic rdy);
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        btc_host_model_i.select();
        btc_host_model_i.xfer(OPC_STATUS, 8, b1);
        btc_host_model_i.xfer(8'h00, 8, b1);
        btc_host_model_i.xfer(8'h00, 8, b2);
        btc_host_model_i.xfer(8'h00, 8, b3);
        btc_host_model_i.deselect();
        check(b1, stat1(rdy), "status byte one");
        check(b2, {rdy, 7'h00}, "status byte two");
        check(b3, stat1(rdy), "status wrap");
    endtask : check_status

    task automatic send(input logic [7:0] opc, input logic [23:0] addr, input int nbytes);
        logic [7:0] rx;
        int s0;
        s0 = starts;
        btc_host_model_i.select();
        btc_host_model_i.xfer(opc, 8, rx);
        for (int i = 0; i < nbytes; i++)
            btc_host_model_i.xfer(i < 3 ? addr[23 - 8 * i -: 8] : 8'h3C, 8, rx);
        repeat (8) @(negedge clk);
        check(starts - s0, 0, "start before select rise");
        btc_host_model_i.deselect();
    endtask : send

    task automatic run_op(input logic [7:0] opc, input logic [23:0] addr, input int nbytes, input logic go,
                          input logic [17:0] exp, input int cycles);
        int s0;
        int n;
        s0 = starts;
        send(opc, addr, nbytes);
        n = 0;
        while (starts == s0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(starts - s0, go, "start count");
        if (go)
        begin
            check({op.kind, op.buffer2, op.page}, exp, "operation fields");
            // the start cycle, already busy, passed before the start counter moved
            n = 1;
            while (ready !== 1'b1 && n < 1000)
            begin
                @(negedge clk);
                n++;
            end
            check(n, cycles + 1, "busy length");
        end
    endtask : run_op

    task automatic t_ops();
        logic [7:0] opcs [6] = '{OPC_XFER_B1, OPC_XFER_B2, OPC_CMP_B1, OPC_CMP_B2, OPC_RFR_B1, OPC_RFR_B2};
        logic [14:0] page;
        btc_op_kind_t kind;
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 6; i++)
            begin
                page_bin_cfg = c[0];
                protect_en = ~c[0];
                cmp_mismatch = i[0] ^ c[0];
                page = {i[2:0], c[0], 11'h5A3};
                kind = i < 2 ? OP_XFER : (i < 4 ? OP_CMP : OP_RFR);
                run_op(opcs[i], c ? {1'b1, page, 8'hC3} : {page, 9'h1AB}, 3, 1'b1, {kind, i[0], page},
                       i < 2 ? NCOPY : (i < 4 ? NCOMP : NRFR));
                if (kind == OP_CMP)
                    comp_exp = cmp_mismatch;
                check_status(1'b1);
            end
    endtask : t_ops

    task automatic t_busy();
        send(OPC_RFR_B2, 24'h123456, 3);
        check_status(1'b0);
        repeat (400) @(negedge clk);
        check_status(1'b1);
    endtask : t_busy

    task automatic t_refused();
        page_bin_cfg = 1'b0;
        run_op(OPC_RFR_B1, {15'h2468, 9'h000}, 4, 1'b1, {OP_RMW, 1'b0, 15'h2468}, NRFR);
        run_op(OPC_XFER_B1, 24'h000000, 2, 1'b0, 18'h0, 0);
        buffer1_suspend_flag = 1'b1;
        run_op(OPC_XFER_B1, 24'h000000, 3, 1'b0, 18'h0, 0);
        cmp_mismatch = ~comp_exp;
        run_op(OPC_CMP_B1, {15'h0F0F, 9'h000}, 3, 1'b1, {OP_CMP, 1'b0, 15'h0F0F}, NCOMP);
        comp_exp = cmp_mismatch;
        buffer1_suspend_flag = 1'b0;
        buffer2_suspend_flag = 1'b1;
        run_op(OPC_RFR_B2, 24'h000000, 3, 1'b0, 18'h0, 0);
        buffer2_suspend_flag = 1'b0;
        check_status(1'b1);
    endtask : t_refused

    task automatic t_abort_status();
        logic [7:0] rx;
        btc_host_model_i.select();
        btc_host_model_i.xfer(OPC_STATUS, 8, rx);
        btc_host_model_i.xfer(8'h00, 3, rx);
        check(so_oe, 1'b1, "output driven in read");
        check(rx[7:5], stat1(1'b1) >> 5, "partial byte");
        btc_host_model_i.deselect();
        repeat (8) @(negedge clk);
        check(so_oe, 1'b0, "output released");
        check_status(1'b1);
    endtask : t_abort_status

    initial
    begin
        reset_n = 1'b0;
        protect_en = 1'b0;
        page_bin_cfg = 1'b0;
        buffer1_suspend_flag = 1'b0;
        buffer2_suspend_flag = 1'b0;
        cmp_mismatch = 1'b0;
        repeat (20) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        check({ready, so_oe, op.start}, 3'h4, "after reset");
        t_ops();
        t_busy();
        t_refused();
        t_abort_status();
        finish_test();
    end

    // about 1.2 ms of traffic is expected
    initial
    begin
        #6000000;
        num_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        finish_test();
    end
endmodule : buffer_transfer_status_cmds_test

`default_nettype wire
